// *** pkg/sfcm_pkg.sv ***
package sfcm_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_START = 8'h04;
    localparam logic [7:0] ADDR_LEN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [7:0] ADDR_CRC = 8'h14;
    // control fields and reset values
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int CTRL_CLK_BIT = 2;
    localparam int CTRL_MOSI_BIT = 3;
    localparam int CTRL_RESTART_BIT = 4;
    localparam logic [3:0] CTRL_RST = 4'h3;
    localparam logic [23:0] START_RST = 24'h000000;
    localparam logic [31:0] LEN_RST = 32'h00000100;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_DONE_BIT = 4;
    localparam int ST_CRC_BIT = 5;
    localparam int ST_MODE_ERR_BIT = 6;
    localparam int ST_VARIANT_LSB = 7;
    localparam int ST_MODE_LSB = 10;
    localparam int ST_RATE_LSB = 13;
    localparam int ST_PULLUP_BIT = 15;
    localparam int ST_PROG_BIT = 16;
    // flash read sequence
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [31:0] CMD_BITS = 32'h00000020;
    localparam logic [31:0] HDR_RATE_IDX = 32'h00000007;
    localparam logic [31:0] CRC_BITS = 32'h00000010;
    localparam logic [2:0] MODE_SPI = 3'h1;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // timing at the 20 mhz reference clock
    localparam int CLK_NS = 50;
    localparam int PROG_LOW_NS = 500;
    localparam int CLEAR_NS = 2000;
    localparam logic [7:0] PROG_LOW_CYC = 8'((PROG_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CLEAR_CYC = 8'((CLEAR_NS + CLK_NS - 1) / CLK_NS);
    // serial clock half periods in reference cycles, per rate option
    localparam logic [1:0] RATE_SLOW = 2'h0;
    localparam logic [3:0] HALF_R0 = 4'ha;
    localparam logic [3:0] HALF_R1 = 4'h5;
    localparam logic [3:0] HALF_R2 = 4'h4;
    localparam logic [3:0] HALF_R3 = 4'h3;
    // pin synchroniser reset pattern, reprogram pin reads high
    localparam logic [10:0] SYNC_RST = 11'h080;

    typedef enum logic [2:0] {
        S_HOLD = 3'h0,
        S_CLEAR = 3'h1,
        S_WAIT_INIT = 3'h2,
        S_CMD = 3'h3,
        S_DATA = 3'h4,
        S_DONE = 3'h5,
        S_FAIL = 3'h6
    } sfcm_state_type;
endpackage

// *** pkg/sfcm_crc_if.sv ***
`timescale 1ns/1ps
interface sfcm_crc_if;
    logic clear;
    logic shift;
    logic bit_val;
    logic [15:0] value;
    modport user (output clear, output shift, output bit_val, input value);
    modport engine (input clear, input shift, input bit_val, output value);
endinterface

// *** logic/sfcm_sync.sv ***
`timescale 1ns/1ps
module sfcm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // two stages; only the second stage is read outside
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// *** logic/sfcm_crc.sv ***
`timescale 1ns/1ps
module sfcm_crc (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    sfcm_crc_if.engine crc
);
    logic fb;

    assign fb = crc.value[15] ^ crc.bit_val;

    // serial crc, msb first, one data bit per shift
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || crc.clear) begin
            crc.value <= sfcm_pkg::CRC_INIT;
        end else if (crc.shift) begin
            crc.value <= {crc.value[14:0], 1'b0} ^ (fb ? sfcm_pkg::CRC_POLY : 16'h0000);
        end
    end
endmodule

// *** logic/sfcm_top.sv ***
`timescale 1ns/1ps
// Operation
// - latch variant pins when init rises
// - send read command then start address
// - capture configuration data from din
// - drive flash select low during read
// - serial clock from divider, rate option
// - drive serial clock throughout the read
// - drive chain data output during configuration
// - init low while clearing, then release
// - crc error drives init low
// - done low until successful completion
// - long reprogram pulse restarts configuration
// - no configuration start while reprogram low
// - flash pins high impedance while reprogram low
// - software drives flash select after configuration
// - init becomes software driven after configuration
// - read command issued once, no retry
// - start slow, speed up per bitstream
module sfcm_top (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [2:0] variant_select_pins_in,
    input wire logic [2:0] mode_pins_in,
    input wire logic io_pullup_disable_in,
    input wire logic reprogram_n_in,
    input wire logic din_in,
    input wire logic init_n_in,
    output logic init_n_out,
    output logic init_n_oe_n_out,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_n_out,
    output logic flash_select_n_out,
    output logic config_serial_clock_out,
    output logic mosi_out,
    output logic chain_data_out,
    output logic io_oe_n_out
);
    sfcm_pkg::sfcm_state_type state;
    logic [10:0] pins_s;
    logic [2:0] variant_s;
    logic [2:0] mode_s;
    logic pullup_s;
    logic prog_s;
    logic din_s;
    logic init_s;
    logic done_s;
    logic init_q;
    logic init_rise;
    logic [3:0] ctrl;
    logic [23:0] start_addr;
    logic [31:0] len;
    logic restart_req;
    logic [2:0] variant_lat;
    logic [2:0] mode_lat;
    logic [1:0] rate;
    logic [3:0] half_cyc;
    logic [3:0] div_cnt;
    logic running;
    logic tick;
    logic rise;
    logic fall;
    logic sclk;
    logic [31:0] bit_cnt;
    logic [31:0] sh_out;
    logic [31:0] rx_word;
    logic [7:0] clr_cnt;
    logic [7:0] prog_cnt;
    logic prog_long;
    logic crc_err;
    logic mode_err;
    logic crc_ok;
    logic ap_write;
    logic [7:0] ap_addr;
    logic bus_acc;
    logic [31:0] rd_val;
    sfcm_crc_if crc_bus ();

    sfcm_sync #(
        .W(11),
        .RST_VAL(sfcm_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .async_in({done_in, init_n_in, din_in, reprogram_n_in, io_pullup_disable_in,
                   mode_pins_in, variant_select_pins_in}),
        .sync_out(pins_s)
    );

    sfcm_crc u_crc (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .crc(crc_bus.engine)
    );

    // unpack synchronised pins
    assign variant_s = pins_s[2:0];
    assign mode_s = pins_s[5:3];
    assign pullup_s = pins_s[6];
    assign prog_s = pins_s[7];
    assign din_s = pins_s[8];
    assign init_s = pins_s[9];
    assign done_s = pins_s[10];
    assign init_rise = init_s && !init_q;

    // rate option to half period of the serial clock
    always_comb begin
        unique case (rate)
            2'h0: half_cyc = sfcm_pkg::HALF_R0;
            2'h1: half_cyc = sfcm_pkg::HALF_R1;
            2'h2: half_cyc = sfcm_pkg::HALF_R2;
            2'h3: half_cyc = sfcm_pkg::HALF_R3;
        endcase
    end

    // divider enable; edges of the serial clock are ticks
    assign running = (state == sfcm_pkg::S_CMD) || (state == sfcm_pkg::S_DATA);
    assign tick = running && (div_cnt == half_cyc - 4'h1);
    assign rise = tick && !sclk;
    assign fall = tick && sclk;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !running || tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // edge history of the init pin
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            init_q <= 1'b0;
        end else begin
            init_q <= init_s;
        end
    end

    // short reprogram glitches are filtered by requiring the full low time
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || prog_s) begin
            prog_cnt <= 8'h00;
        end else if (prog_cnt != sfcm_pkg::PROG_LOW_CYC) begin
            prog_cnt <= prog_cnt + 8'h01;
        end
    end
    assign prog_long = (prog_cnt == sfcm_pkg::PROG_LOW_CYC);

    // configuration sequencer
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state <= sfcm_pkg::S_CLEAR;
            clr_cnt <= 8'h00;
            bit_cnt <= 32'h0;
        end else begin
            unique case (state)
                sfcm_pkg::S_HOLD: begin
                    if (prog_s) begin
                        state <= sfcm_pkg::S_CLEAR;
                        clr_cnt <= 8'h00;
                    end
                end
                sfcm_pkg::S_CLEAR: begin
                    if (!prog_s) begin
                        state <= sfcm_pkg::S_HOLD;
                    end else if (clr_cnt == sfcm_pkg::CLEAR_CYC - 8'h01) begin
                        state <= sfcm_pkg::S_WAIT_INIT;
                    end else begin
                        clr_cnt <= clr_cnt + 8'h01;
                    end
                end
                sfcm_pkg::S_WAIT_INIT: begin
                    // an outside party may hold init low to stall here
                    if (!prog_s) begin
                        state <= sfcm_pkg::S_HOLD;
                    end else if (init_rise) begin
                        bit_cnt <= 32'h0;
                        if (mode_s == sfcm_pkg::MODE_SPI) begin
                            state <= sfcm_pkg::S_CMD;
                        end else begin
                            state <= sfcm_pkg::S_FAIL;
                        end
                    end
                end
                sfcm_pkg::S_CMD: begin
                    if (fall && bit_cnt == sfcm_pkg::CMD_BITS) begin
                        state <= sfcm_pkg::S_DATA;
                        bit_cnt <= 32'h0;
                    end else if (rise) begin
                        bit_cnt <= bit_cnt + 32'h1;
                    end
                end
                sfcm_pkg::S_DATA: begin
                    // no retry: a failed read ends in the fail state
                    if (fall && bit_cnt == len) begin
                        state <= crc_ok ? sfcm_pkg::S_DONE : sfcm_pkg::S_FAIL;
                    end else if (rise) begin
                        bit_cnt <= bit_cnt + 32'h1;
                    end
                end
                sfcm_pkg::S_DONE, sfcm_pkg::S_FAIL: begin
                end
                default: begin
                    state <= sfcm_pkg::S_CLEAR;
                end
            endcase
            if (prog_long && state != sfcm_pkg::S_HOLD) begin
                state <= sfcm_pkg::S_HOLD;
            end else if (restart_req) begin
                state <= sfcm_pkg::S_CLEAR;
                clr_cnt <= 8'h00;
            end
        end
    end

    // strap capture on the rising init edge
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            variant_lat <= 3'h0;
            mode_lat <= 3'h0;
        end else if (state == sfcm_pkg::S_WAIT_INIT && init_rise) begin
            variant_lat <= variant_s;
            mode_lat <= mode_s;
        end
    end

    // command and address shifter, loaded once per attempt
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sh_out <= 32'h0;
        end else if (state == sfcm_pkg::S_WAIT_INIT && init_rise) begin
            sh_out <= {sfcm_pkg::READ_CMD, start_addr};
        end else if (state == sfcm_pkg::S_CMD && fall) begin
            sh_out <= {sh_out[30:0], 1'b0};
        end
    end

    // receive path: din sampled on the rising serial clock edge
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rx_word <= 32'h0;
            chain_data_out <= 1'b0;
        end else if (state == sfcm_pkg::S_DATA && rise) begin
            rx_word <= {rx_word[30:0], din_s};
            chain_data_out <= din_s;
        end
    end

    // rate starts slow and follows the header bits 6..7
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || state == sfcm_pkg::S_CLEAR) begin
            rate <= sfcm_pkg::RATE_SLOW;
        end else if (state == sfcm_pkg::S_DATA && rise && bit_cnt == sfcm_pkg::HDR_RATE_IDX) begin
            rate <= {rx_word[0], din_s};
        end
    end

    // crc over every bit ahead of the 16-bit trailer
    assign crc_bus.clear = (state == sfcm_pkg::S_WAIT_INIT) && init_rise;
    assign crc_bus.shift = (state == sfcm_pkg::S_DATA) && rise
                           && (bit_cnt < len - sfcm_pkg::CRC_BITS);
    assign crc_bus.bit_val = din_s;
    assign crc_ok = (crc_bus.value == rx_word[15:0]);

    // sticky failure causes, cleared when a new attempt starts
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || state == sfcm_pkg::S_CLEAR) begin
            crc_err <= 1'b0;
            mode_err <= 1'b0;
        end else if (state == sfcm_pkg::S_DATA && fall && bit_cnt == len && !crc_ok) begin
            crc_err <= 1'b1;
        end else if (state == sfcm_pkg::S_WAIT_INIT && init_rise && mode_s != sfcm_pkg::MODE_SPI) begin
            mode_err <= 1'b1;
        end
    end

    // serial clock, select and data pins
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sclk <= 1'b0;
            flash_select_n_out <= 1'b1;
            mosi_out <= 1'b0;
            io_oe_n_out <= 1'b1;
        end else begin
            io_oe_n_out <= !prog_s;
            if (state == sfcm_pkg::S_DONE) begin
                sclk <= ctrl[sfcm_pkg::CTRL_CLK_BIT];
                flash_select_n_out <= ctrl[sfcm_pkg::CTRL_SEL_BIT];
                mosi_out <= ctrl[sfcm_pkg::CTRL_MOSI_BIT];
            end else begin
                sclk <= running ? (sclk ^ tick) : 1'b0;
                flash_select_n_out <= !running;
                mosi_out <= (state == sfcm_pkg::S_CMD) ? sh_out[31] : 1'b0;
            end
        end
    end
    assign config_serial_clock_out = sclk;

    // open-drain done pin; init open-drain except in the done state, where ctrl drives its level
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            init_n_out <= 1'b0;
            init_n_oe_n_out <= 1'b0;
            done_oe_n_out <= 1'b0;
        end else begin
            init_n_out <= (state == sfcm_pkg::S_DONE) ? ctrl[sfcm_pkg::CTRL_INIT_BIT] : 1'b0;
            unique case (state)
                sfcm_pkg::S_HOLD, sfcm_pkg::S_CLEAR: init_n_oe_n_out <= 1'b0;
                sfcm_pkg::S_FAIL: init_n_oe_n_out <= !crc_err;
                sfcm_pkg::S_DONE: init_n_oe_n_out <= 1'b0;
                default: init_n_oe_n_out <= 1'b1;
            endcase
            done_oe_n_out <= (state == sfcm_pkg::S_DONE);
        end
    end
    assign done_out = 1'b0;

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign bus_acc = hsel_in && htrans_in[1] && hready_in;

    always_comb begin
        rd_val = 32'h0;
        unique case (haddr_in[7:0])
            sfcm_pkg::ADDR_CTRL: rd_val = {28'h0, ctrl};
            sfcm_pkg::ADDR_START: rd_val = {8'h00, start_addr};
            sfcm_pkg::ADDR_LEN: rd_val = len;
            sfcm_pkg::ADDR_STATUS: begin
                rd_val[sfcm_pkg::ST_STATE_LSB +: 3] = state;
                rd_val[sfcm_pkg::ST_DONE_BIT] = done_s;
                rd_val[sfcm_pkg::ST_CRC_BIT] = crc_err;
                rd_val[sfcm_pkg::ST_MODE_ERR_BIT] = mode_err;
                rd_val[sfcm_pkg::ST_VARIANT_LSB +: 3] = variant_lat;
                rd_val[sfcm_pkg::ST_MODE_LSB +: 3] = mode_lat;
                rd_val[sfcm_pkg::ST_RATE_LSB +: 2] = rate;
                rd_val[sfcm_pkg::ST_PULLUP_BIT] = pullup_s;
                rd_val[sfcm_pkg::ST_PROG_BIT] = prog_s;
            end
            sfcm_pkg::ADDR_DATA: rd_val = rx_word;
            sfcm_pkg::ADDR_CRC: rd_val = {rx_word[15:0], crc_bus.value};
            default: rd_val = 32'h0;
        endcase
    end

    // read data is fetched in the address phase so it stands from a flop
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            hrdata_out <= 32'h0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_write <= bus_acc && hwrite_in && (hsize_in == sfcm_pkg::HSIZE_WORD);
            ap_addr <= haddr_in[7:0];
            if (bus_acc && !hwrite_in) begin
                hrdata_out <= rd_val;
            end
        end
    end

    // register writes land in the data phase
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctrl <= sfcm_pkg::CTRL_RST;
            start_addr <= sfcm_pkg::START_RST;
            len <= sfcm_pkg::LEN_RST;
            restart_req <= 1'b0;
        end else begin
            restart_req <= ap_write && (ap_addr == sfcm_pkg::ADDR_CTRL)
                           && hwdata_in[sfcm_pkg::CTRL_RESTART_BIT];
            if (ap_write && ap_addr == sfcm_pkg::ADDR_CTRL) begin
                ctrl <= hwdata_in[3:0];
            end
            if (ap_write && ap_addr == sfcm_pkg::ADDR_START) begin
                start_addr <= hwdata_in[23:0];
            end
            if (ap_write && ap_addr == sfcm_pkg::ADDR_LEN) begin
                len <= hwdata_in;
            end
        end
    end
endmodule

// *** test/sfcm_top_properties.sv ***
`timescale 1ns/1ps
module sfcm_top_properties (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic reprogram_n_in,
    input wire logic init_n_out,
    input wire logic init_n_oe_n_out,
    input wire logic done_oe_n_out,
    input wire logic flash_select_n_out,
    input wire logic config_serial_clock_out,
    input wire logic mosi_out,
    input wire logic io_oe_n_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    // a flash read opens when select falls
    sequence read_opens;
        $fell(flash_select_n_out);
    endsequence
    // low long enough to count as a reprogram request
    sequence long_reprogram;
        !reprogram_n_in [*8] ##1 !reprogram_n_in [*4];
    endsequence

    chk_init_clear_low: assert property ($fell(srst_in) |-> !init_n_oe_n_out [*8])
        else $error("init not driven low while clearing");
    chk_select_held: assert property (read_opens |-> !flash_select_n_out [*8])
        else $error("flash select dropped early");
    chk_cmd_leading: assert property (read_opens |-> !mosi_out [*8])
        else $error("read command does not open with zeros");
    chk_first_clock: assert property (
        read_opens |-> !config_serial_clock_out [*8] ##[1:4] config_serial_clock_out)
        else $error("first serial clock not at slow rate");
    chk_clock_high_min: assert property (
        $rose(config_serial_clock_out) |-> config_serial_clock_out [*3])
        else $error("serial clock high phase too short");
    chk_clock_runs: assert property (!flash_select_n_out && !io_oe_n_out |-> ##[1:21]
        ($changed(config_serial_clock_out) || flash_select_n_out || io_oe_n_out))
        else $error("serial clock stalled during read");
    chk_io_hiz: assert property (!reprogram_n_in [*4] |-> io_oe_n_out)
        else $error("pins driven while reprogram low");
    chk_prog_hold: assert property (long_reprogram |-> ##[1:6]
        (!done_oe_n_out && !init_n_oe_n_out && !init_n_out))
        else $error("long reprogram did not reset pins");
    chk_done_after_read: assert property (
        $rose(done_oe_n_out) |-> $past(flash_select_n_out) == 1'b0)
        else $error("done released without a read");
    chk_init_after_done: assert property (done_oe_n_out |-> !init_n_oe_n_out)
        else $error("init not driven after done");
endmodule

bind sfcm_top sfcm_top_properties chk (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .reprogram_n_in(reprogram_n_in),
    .init_n_out(init_n_out),
    .init_n_oe_n_out(init_n_oe_n_out),
    .done_oe_n_out(done_oe_n_out),
    .flash_select_n_out(flash_select_n_out),
    .config_serial_clock_out(config_serial_clock_out),
    .mosi_out(mosi_out),
    .io_oe_n_out(io_oe_n_out)
);

// *** test/sfcm_flash_model.sv ***
`timescale 1ns/1ps
module sfcm_flash_model (
    input wire logic sel_n_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic [63:0] image_in,
    output logic miso_out,
    output logic [31:0] cmd_out
);
    int fall_cnt = 0;
    initial miso_out = 1'b0;
    initial cmd_out = 32'h0;
    // command and address shift in on the rising clock, msb first
    always @(posedge sck_in) begin
        if (!sel_n_in && fall_cnt < 32) begin
            cmd_out <= {cmd_out[30:0], mosi_in};
        end
    end
    // data leaves on the falling clock; outside the read the line is not held
    always @(negedge sck_in) begin
        if (!sel_n_in) begin
            fall_cnt = fall_cnt + 1;
            if (fall_cnt >= 32 && fall_cnt < 96) begin
                miso_out <= image_in[95 - fall_cnt];
            end else begin
                miso_out <= !miso_out;
            end
        end
    end
    // deselect ends the read, so a restart must send a new command
    always @(posedge sel_n_in) begin
        fall_cnt = 0;
        miso_out <= !miso_out;
    end
endmodule

// *** test/tb_spi_flash_config_master.sv ***
`timescale 1ns/1ps
module tb_spi_flash_config_master;
    logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwr = 1'b0, rpg = 1'b1, ihold = 1'b1, pud = 1'b0;
    logic [1:0] htr = 2'h0;
    logic [2:0] variant = 3'h0, mode = 3'h1;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, cmd;
    logic rdy, hresp, ini_o, ini_oe, dn_o, dn_oe, sel, sck, mosi, chain, io_oe, miso;
    logic [63:0] img = 64'h0;
    logic [23:0] st = 24'h0;
    logic [15:0] rnd = 16'h6ced;
    int bad_count = 0, n_tests = 0, cyc = 0;
    // open-drain init with pull-up, which the outside may hold low
    wire init_w = (ini_oe ? 1'b1 : ini_o) & !ihold;

    sfcm_top dut (
        .ref_clk_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(ha), .htrans_in(htr),
        .hwrite_in(hwr), .hsize_in(sfcm_pkg::HSIZE_WORD), .hready_in(rdy), .hwdata_in(hwd),
        .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out(hresp),
        .variant_select_pins_in(variant), .mode_pins_in(mode), .io_pullup_disable_in(pud),
        .reprogram_n_in(rpg), .din_in(miso), .init_n_in(init_w), .init_n_out(ini_o),
        .init_n_oe_n_out(ini_oe), .done_in(dn_oe ? 1'b1 : dn_o), .done_out(dn_o),
        .done_oe_n_out(dn_oe), .flash_select_n_out(sel), .config_serial_clock_out(sck),
        .mosi_out(mosi), .chain_data_out(chain), .io_oe_n_out(io_oe)
    );
    // select pulled up and clock quiet while the pins float
    sfcm_flash_model flash (
        .sel_n_in(io_oe | sel), .sck_in(!io_oe & sck), .mosi_in(mosi),
        .image_in(img), .miso_out(miso), .cmd_out(cmd)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // crc over all stream bits before the trailer, msb first
    function automatic logic [15:0] crc16(input logic [63:0] v);
        logic [15:0] c;
        c = sfcm_pkg::CRC_INIT;
        for (int i = 63; i >= 16; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? sfcm_pkg::CRC_POLY : 16'h0);
        end
        return c;
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htr <= 2'h2;
        hwr <= wr;
        ha <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htr <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        q = hrd;
        chk("resp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wait_st(input logic [2:0] s);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, sfcm_pkg::ADDR_STATUS, 32'h0, q);
            n++;
        end while (q[2:0] !== s && n < 3000);
        chk("state", {29'h0, q[2:0]}, {29'h0, s});
    endtask

    // build a stream: header with rate bits, payload, crc trailer
    task automatic cfg(input logic [1:0] r, input logic bad);
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            img[16*i +: 16] = rnd;
        end
        img[57:56] = r;
        img[15:0] = crc16(img) ^ {15'h0, bad};
        @(posedge clk);
        ihold <= 1'b1;
        variant <= rnd[2:0];
        pud <= rnd[3];
        wait_st(3'h2);
        repeat (30) @(posedge clk);
        chk("sel idle", {31'h0, sel}, 32'h1);
        ihold <= 1'b0;
        wait_st(bad ? 3'h6 : 3'h5);
        chk("cmd", cmd, {sfcm_pkg::READ_CMD, st});
        bus(1'b0, sfcm_pkg::ADDR_DATA, 32'h0, q);
        chk("data", q, img[31:0]);
        bus(1'b0, sfcm_pkg::ADDR_CRC, 32'h0, q);
        chk("crc", q, {img[15:0], crc16(img)});
        bus(1'b0, sfcm_pkg::ADDR_STATUS, 32'h0, q);
        chk("status", {23'h0, q[16:13], q[9:7], q[5:4]},
            {23'h0, rpg, pud, r, variant, bad, !bad});
        chk("pins", {28'h0, dn_oe, ini_oe, ini_o, chain}, {28'h0, !bad, 1'b0, !bad, img[0]});
        if (!bad) begin
            chk("sel after", {31'h0, sel}, 32'h1);
        end
        $display("test config rate %0d fault %0d done", r, bad);
    endtask

    initial begin
        logic [31:0] q;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("init oe", {31'h0, ini_oe}, 32'h0);
        chk("done oe", {31'h0, dn_oe}, 32'h0);
        bus(1'b0, sfcm_pkg::ADDR_CTRL, 32'h0, q);
        chk("ctrl", q, {28'h0, sfcm_pkg::CTRL_RST});
        bus(1'b0, sfcm_pkg::ADDR_START, 32'h0, q);
        chk("start", q, {8'h0, sfcm_pkg::START_RST});
        bus(1'b0, sfcm_pkg::ADDR_LEN, 32'h0, q);
        chk("len", q, sfcm_pkg::LEN_RST);
        bus(1'b1, 8'h18, 32'hffffffff, q);
        bus(1'b0, 8'h18, 32'h0, q);
        chk("unmapped", q, 32'h0);
        rnd = lfsr(rnd);
        st = {rnd[7:0], rnd};
        bus(1'b1, sfcm_pkg::ADDR_START, {8'h0, st}, q);
        bus(1'b1, sfcm_pkg::ADDR_LEN, 32'h40, q);
        $display("test registers done");
        cfg(2'h3, 1'b0);
        bus(1'b1, sfcm_pkg::ADDR_CTRL, 32'h13, q);
        cfg(2'h0, 1'b1);
        // long reprogram pulse floats the pins and holds the device
        rpg <= 1'b0;
        repeat (5) @(posedge clk);
        chk("io hiz", {31'h0, io_oe}, 32'h1);
        wait_st(3'h0);
        chk("held", {28'h0, dn_o, dn_oe, ini_oe, ini_o}, 32'h0);
        ihold <= 1'b1;
        mode <= 3'h2;
        rpg <= 1'b1;
        wait_st(3'h2);
        ihold <= 1'b0;
        wait_st(3'h6);
        bus(1'b0, sfcm_pkg::ADDR_STATUS, 32'h0, q);
        chk("mode err", {28'h0, q[12:10], q[6]}, {28'h0, 3'h2, 1'b1});
        $display("test reprogram and mode done");
        mode <= 3'h1;
        bus(1'b1, sfcm_pkg::ADDR_CTRL, 32'h13, q);
        cfg(2'h3, 1'b0);
        stop_test();
    end

    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            stop_test();
        end
    end
endmodule
